// *** bench/pcr_core_model.sv ***
// Purpose : Behavioural processor core facing the control registers
// Assumes : Same clock as the block; drives just after rising edges
// Notes   : Program counter parked at zero so breakpoint matching stays idle
`timescale 1ns/1ps
module pcr_core_model (
   input  wire logic   clk,
   output logic        alu_update,
   output logic        alu_sub,
   output logic [15:0] alu_a,
   output logic [15:0] alu_b,
   output logic        gie,
   output logic [3:0]  gpr_index,
   output logic [15:0] irq_pending,
   output logic [15:0] cpu_pc
);
   // ==========================================================================
   // Idle values at time zero
   initial begin
      {alu_update, alu_sub, alu_a, alu_b, gie, gpr_index, irq_pending, cpu_pc} = '0;
   end
   // One arithmetic result, held for exactly one capture edge
   task automatic alu_op(input logic s, input logic [15:0] a, input logic [15:0] b);
      @(posedge clk);
      {alu_update, alu_sub, alu_a, alu_b} <= {1'b1, s, a, b};
      @(posedge clk);
      alu_update <= 1'b0;
   endtask
   // Core status levels: interrupt enable, register number, pending requests
   task automatic ctl(input logic g, input logic [3:0] n, input logic [15:0] p);
      @(posedge clk);
      {gie, gpr_index, irq_pending} <= {g, n, p};
   endtask
endmodule

// *** bench/pcr_regs_monitor.sv ***
// Purpose : Port-level checker for the processor control register block
// Assumes : One clock, synchronous active-high reset
// Notes   : Bound onto every pcr_regs instance after the module
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_regs_monitor #(
   parameter logic [15:0] REVISION = 16'h0A5A   // Arbitrary revision code
) (
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic [15:0]        addr,
   input  wire pcr_pkg::pcr_word_t wdata,
   input  wire logic               wr,
   input  wire logic               rd,
   input  wire pcr_pkg::pcr_word_t rdata,
   input  wire logic               gie,
   input  wire logic [3:0]         gpr_index,
   input  wire logic [15:0]        gpr_ram_addr,
   input  wire logic               boost_not_ok,
   input  wire logic               cpu_clk_en,
   input  wire logic               periph_clk_en,
   input  wire logic               sleep_active
);
   import pcr_pkg::*;
   // ==========================================================================
   // Properties, all on the one clock and reset
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_FLAG_RSVD: assert property (
      rd && addr == `PCR_OFF_FLAGS |=> rdata[15:5] == 11'h000)
      else $error("Flag register reserved bits not zero");
   // Gie must be steady across the capture so either sampling point agrees
   AST_FLAG_GIE: assert property (
      rd && addr == `PCR_OFF_FLAGS && $stable(gie) && !$past(reset) |=> rdata[4] == $past(gie))
      else $error("Global enable flag does not follow gie");
   AST_REV_CODE: assert property (
      rd && addr == `PCR_OFF_REV |=> rdata == REVISION)
      else $error("Revision read wrong");
   AST_GPR_LOW: assert property (
      gpr_ram_addr[3:0] == {gpr_index[2:0], 1'b0})
      else $error("General register address low bits wrong");
   AST_SPEED_RSVD: assert property (
      rd && addr == `PCR_OFF_SPEED |=> rdata[15:4] == 12'h000)
      else $error("Divider reserved bits not zero");
   AST_PWR_RO: assert property (
      rd && addr == `PCR_OFF_POWER |=> (rdata & 16'hA46B) == 16'h0000 && rdata[2] == $past(boost_not_ok))
      else $error("Power register read-only bits wrong");
   AST_SLEEP_ENTER: assert property (
      wr && addr == `PCR_OFF_POWER && wdata[1] && !sleep_active |=> sleep_active)
      else $error("Sleep not entered after write");
   AST_PERIPH_CLK: assert property (
      periph_clk_en == !sleep_active)
      else $error("Peripheral clock gated outside sleep");
   AST_SLEEP_CPU: assert property (
      sleep_active |-> !cpu_clk_en)
      else $error("Processor clocked during sleep");
endmodule
bind pcr_regs pcr_regs_monitor #(.REVISION(REVISION)) i_pcr_regs_monitor (.clk(clk),
   .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gie(gie),
   .gpr_index(gpr_index), .gpr_ram_addr(gpr_ram_addr), .boost_not_ok(boost_not_ok),
   .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .sleep_active(sleep_active));

// *** bench/tb_top.sv ***
// Purpose : Self-checking bench for the processor control registers
// Assumes : 10 MHz clock, synchronous reset held two cycles
// Notes   : Expected values come from the small models below, never the design
`timescale 1ns/1ps
`include "pcr_map.svh"
module tb_top;
   import pcr_pkg::*;
   localparam logic [15:0] REV = 16'h3C5A;   // Arbitrary revision code
   logic        clk, reset, wr, rd, e2, hrd, boost, alu_update, alu_sub, gie;
   logic        cpu_clk_en, periph_clk_en, sleep_active, break_hit, irq;
   logic [15:0] addr, alu_a, alu_b, irq_pending, cpu_pc, gpr_ram_addr, usb_diag, bank;
   logic [3:0]  gpr_index;
   logic [15:0] opa, opb;                    // Operands handed to the core model
   logic [15:0] ca [5] = '{16'h7FFF, 16'hFFFF, 16'h0000, 16'h8000, 16'h0001};
   pcr_word_t   wdata, rdata;
   integer      failures = 0, cmp_count = 0, seed = 32'h095c, i, n, c;
   // Address, reset value, read-back after writing all ones (power skipped)
   logic [15:0] ra [8] = '{`PCR_OFF_FLAGS, `PCR_OFF_BANK, `PCR_OFF_REV, `PCR_OFF_SPEED,
                           `PCR_OFF_POWER, `PCR_OFF_IRQ_EN, `PCR_OFF_DIAG, 16'hC006};
   logic [15:0] rv [8] = '{16'h0000, 16'h0100, REV, 16'h000F, 16'h0000, 16'h0010, 16'h0000, 16'h0000};
   logic [15:0] rw [8] = '{16'h0000, 16'hFFF0, REV, 16'h000F, 16'h0000, 16'h1BFF, 16'h0000, 16'h0000};
   pcr_regs #(.REVISION(REV)) i_pcr_regs (.clk(clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alu_update(alu_update),
      .alu_sub(alu_sub), .alu_a(alu_a), .alu_b(alu_b), .gie(gie), .gpr_index(gpr_index),
      .gpr_ram_addr(gpr_ram_addr), .irq_pending(irq_pending), .cpu_pc(cpu_pc),
      .usb_port_engine2_act(e2), .usb_port_engine1_act(1'b0), .otg_act(1'b0),
      .fast_serial_port_rx(1'b0), .spi_sel_n(1'b1), .parallel_host_port_rd(hrd),
      .gpi_pins(2'b00), .boost_not_ok(boost), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .sleep_active(sleep_active), .break_hit(break_hit),
      .usb_diag(usb_diag), .irq(irq));
   pcr_core_model i_pcr_core_model (.clk(clk), .alu_update(alu_update), .alu_sub(alu_sub),
      .alu_a(alu_a), .alu_b(alu_b), .gie(gie), .gpr_index(gpr_index),
      .irq_pending(irq_pending), .cpu_pc(cpu_pc));
   // ==========================================================================
   // Clock and shared tasks
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
      @(posedge clk);
      {addr, wdata, wr} <= {a, v, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just there
   task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Bounded wait for a level on a design flag; running out is a mismatch
   task automatic wait_lvl(input logic want, input int which);
      for (n = 0; n < 30 && (which ? cpu_clk_en : sleep_active) !== want; n++) @(posedge clk);
      if (n == 30) begin
         failures++;
         final_report;
      end
   endtask
   task automatic count_en(input int cyc);
      c = 0;
      repeat (cyc) begin
         @(posedge clk);
         #1 c += (cpu_clk_en === 1'b1);
      end
   endtask
   // Flag model in plain integers: sign, signed overflow, carry or borrow, zero
   function automatic logic [15:0] flags_of(input int s, input int a, input int b, input int g);
      int r = s ? a - b : a + b;
      int v = s ? ((a ^ b) & (a ^ r)) : (~(a ^ b) & (a ^ r));
      return {11'h000, g[0], r[15], v[15], r[16], r[15:0] == 16'h0000};
   endfunction
   // ==========================================================================
   // Main sequence
   initial begin
      {reset, wr, rd, e2, hrd, boost, addr, wdata} = {1'b1, 37'h0};
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      for (i = 0; i < 8; i++) rchk(ra[i], rv[i]);
      // All ones everywhere but power: read-only and reserved places must not move
      for (i = 0; i < 8; i++) if (i != 4) wr_reg(ra[i], 16'hFFFF);
      for (i = 0; i < 8; i++) rchk(ra[i], rw[i]);
      bank = 16'($random(seed)) & 16'hFFF0;
      wr_reg(`PCR_OFF_BANK, bank);
      rchk(`PCR_OFF_BANK, bank);
      for (i = 0; i < 16; i++) begin
         i_pcr_core_model.ctl(1'b1, 4'(i), 16'h0000);
         @(posedge clk);
         chk(gpr_ram_addr, (bank | 16'(i << 1)) & 16'hFFFE);
      end
      // Corner operands first, then random ones
      for (i = 0; i < 10; i++) begin
         opa = (i < 5) ? ca[i] : 16'($random(seed));
         opb = (i < 5) ? 16'h0001 : 16'($random(seed));
         i_pcr_core_model.alu_op(i[0] ^ (i == 2), opa, opb);
         rchk(`PCR_OFF_FLAGS, flags_of(i[0] ^ (i == 2), opa, opb, 1));
      end
      for (i = 0; i < 3; i++) begin
         n = (i == 0) ? 0 : (i == 1) ? 3 : 15;
         wr_reg(`PCR_OFF_SPEED, 16'(n));
         count_en(4 * (n + 1));
         chk(16'(c), 16'h0004);
      end
      // Halt: processor idle until an enabled request arrives
      wr_reg(`PCR_OFF_IRQ_EN, 16'h0001);
      wr_reg(`PCR_OFF_POWER, 16'h0001);
      count_en(8);
      chk(16'(c), 16'h0000);
      chk(16'(periph_clk_en), 16'h0001);
      i_pcr_core_model.ctl(1'b1, 4'h0, 16'h0001);
      wait_lvl(1'b1, 1);
      i_pcr_core_model.ctl(1'b1, 4'h0, 16'h0000);
      // Sleep woken by an engine two transition, then the wake event interrupt
      wr_reg(`PCR_OFF_EVT_EN, 16'h0001);
      wr_reg(`PCR_OFF_POWER, 16'h4002);
      #1 chk(16'(sleep_active), 16'h0001);
      e2 <= ~e2;
      wait_lvl(1'b0, 0);
      boost <= 1'b1;
      rchk(`PCR_OFF_POWER, 16'h4004);
      // Halt end from the earlier halt is sticky as well
      rchk(`PCR_OFF_EVT_STAT, 16'h0003);
      chk(16'(irq), 16'h0001);
      wr_reg(`PCR_OFF_EVT_EN, 16'h0000);
      #1 chk(16'(irq), 16'h0000);
      wr_reg(`PCR_OFF_EVT_CLR, 16'h0007);
      rchk(`PCR_OFF_EVT_STAT, 16'h0000);
      // Engine two disabled: only the host port read may wake
      wr_reg(`PCR_OFF_POWER, 16'h0082);
      e2 <= ~e2;
      count_en(10);
      chk(16'(sleep_active), 16'h0001);
      hrd <= 1'b1;
      wait_lvl(1'b0, 0);
      final_report;
   end
endmodule

// *** rtl/pcr_regs.sv ***
// Purpose : Processor control register group with sleep, halt and clock divider logic
// Assumes : Synchronous active-high reset; all inputs from other domains are raw pins
// Notes   : Reads return data one cycle after the read strobe
// Notes on behaviour
// - Flag register is read-only, writes ignored
// - Bit 4 shows global interrupt enable
// - Bit 3 holds result sign bit
// - Bit 2 shows arithmetic overflow
// - Bit 1 shows carry or borrow
// - Bit 0 shows zero result
// - Bank base bits 15:4, reset 0x0100
// - Register address is base OR n shifted
// - Revision register returns read-only code
// - Processor runs at clock divided N+1
// - Divider slows only the processor
// - Power register selects sleep or halt
// - Bit 14 wakes on engine two transition
// - Bit 2 reads boost not ok
// - Sleep bit stops clock until wake
// - Halt stops processor until enabled interrupt
// - Bit 7 wakes on host port read
`timescale 1ns/1ps
`include "pcr_map.svh"

module pcr_regs #(
   parameter logic [15:0] REVISION = 16'h0A5A   // Arbitrary revision code
) (
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire logic [15:0]     addr,
   input  wire pcr_pkg::pcr_word_t wdata,
   input  wire logic            wr,
   input  wire logic            rd,
   output pcr_pkg::pcr_word_t   rdata,
   // ALU and core status, same clock
   input  wire logic            alu_update,
   input  wire logic            alu_sub,
   input  wire logic [15:0]     alu_a,
   input  wire logic [15:0]     alu_b,
   input  wire logic            gie,
   input  wire logic [3:0]      gpr_index,
   output logic [15:0]          gpr_ram_addr,
   input  wire logic [15:0]     irq_pending,
   input  wire logic [15:0]     cpu_pc,
   // Raw wake pins and boost status, asynchronous
   input  wire logic            usb_port_engine2_act,
   input  wire logic            usb_port_engine1_act,
   input  wire logic            otg_act,
   input  wire logic            fast_serial_port_rx,
   input  wire logic            spi_sel_n,
   input  wire logic            parallel_host_port_rd,
   input  wire logic [1:0]      gpi_pins,
   input  wire logic            boost_not_ok,
   // Clock controls, breakpoint, diagnostic and interrupt outputs
   output logic                 cpu_clk_en,
   output logic                 periph_clk_en,
   output logic                 sleep_active,
   output logic                 break_hit,
   output logic [15:0]          usb_diag,
   output logic                 irq
);
   import pcr_pkg::*;

   // ==========================================================================
   // Storage
   logic [15:0] flags_reg;                      // Arithmetic and GIE flags
   logic [15:0] bank_reg;                       // Register bank base
   logic [3:0]  speed_reg;                      // Divider field N
   logic [15:0] power_reg;                      // Wake enables only; sleep and halt bits not stored
   logic [15:0] irq_en_reg;                     // Interrupt source mask
   logic [15:0] break_reg;                      // Breakpoint address
   logic [15:0] diag_reg;                       // Write-only diagnostic
   logic [2:0]  evt_stat_reg;                   // Sticky events
   logic [2:0]  evt_en_reg;                     // Event enables
   logic [3:0]  div_cnt_reg;                    // Divider counter
   pcr_state_t  state_reg;                      // Power state
   logic [7:0]  sync1_reg;                      // Synchroniser first stage
   logic [7:0]  sync2_reg;                      // Synchroniser second stage
   logic [7:0]  sync3_reg;                      // Edge history
   logic [16:0] sum;                            // Add with carry out
   logic [16:0] diff;                           // Subtract with borrow
   logic [15:0] res;                            // Selected result
   logic        ovf;                            // Signed overflow
   logic        wake;                           // Any enabled wake
   logic [2:0]  evt_set;                        // Event pulses

   // Address match helper, used by the write decode only; reads decode with a case
   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == off);
   endfunction

   // ==========================================================================
   // Arithmetic flags
   always_comb begin
      sum  = {1'b0, alu_a} + {1'b0, alu_b};
      diff = {1'b0, alu_a} - {1'b0, alu_b};
      res  = alu_sub ? diff[15:0] : sum[15:0];
      // Signed overflow: operand signs vs. result sign
      if (alu_sub) begin
         ovf = (alu_a[15] != alu_b[15]) && (res[15] != alu_a[15]);
      end else begin
         ovf = (alu_a[15] == alu_b[15]) && (res[15] != alu_a[15]);
      end
   end

   // Flags update only from the core; bus writes never reach them
   always_ff @(posedge clk) begin
      if (reset) begin
         flags_reg <= `PCR_RST_ZERO;
      end else begin
         flags_reg[`PCR_FLAG_GIE] <= gie;
         if (alu_update) begin
            flags_reg[`PCR_FLAG_NEG]   <= res[15];
            flags_reg[`PCR_FLAG_OVF]   <= ovf;
            flags_reg[`PCR_FLAG_CARRY] <= alu_sub ? diff[16] : sum[16];
            flags_reg[`PCR_FLAG_ZERO]  <= (res == 16'h0000);
         end
      end
   end

   // ==========================================================================
   // Writable registers; masks drop reserved and read-only bits
   always_ff @(posedge clk) begin
      if (reset) begin
         bank_reg   <= `PCR_RST_BANK;
         speed_reg  <= `PCR_RST_SPEED;
         irq_en_reg <= `PCR_RST_IRQ_EN;
         break_reg  <= `PCR_RST_ZERO;
         diag_reg   <= `PCR_RST_ZERO;
         evt_en_reg <= 3'b000;
      end else if (wr) begin
         if (hit(addr, `PCR_OFF_BANK)) begin
            bank_reg <= wdata & `PCR_BANK_MASK;
         end
         if (hit(addr, `PCR_OFF_SPEED)) begin
            speed_reg <= wdata[3:0];
         end
         if (hit(addr, `PCR_OFF_IRQ_EN)) begin
            irq_en_reg <= (wdata & `PCR_IRQEN_MASK) | `PCR_RST_IRQ_EN;
         end
         if (hit(addr, `PCR_OFF_BREAK)) begin
            break_reg <= wdata;
         end
         if (hit(addr, `PCR_OFF_DIAG)) begin
            diag_reg <= wdata;
         end
         if (hit(addr, `PCR_OFF_EVT_EN)) begin
            evt_en_reg <= wdata[2:0];
         end
      end
   end

   // Bank address mapping for general_purpose_registers
   always_comb begin
      gpr_ram_addr = (bank_reg | {11'd0, gpr_index, 1'b0}) & 16'hFFFE;
   end

   // ==========================================================================
   // Wake pin synchronisers; only stage two and later feed logic
   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
         sync3_reg <= 8'h00;
      end else begin
         sync1_reg <= {gpi_pins, parallel_host_port_rd, spi_sel_n, fast_serial_port_rx,
                       otg_act, usb_port_engine1_act, usb_port_engine2_act};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Wake decode: each enable gates its own source
   always_comb begin
      wake = 1'b0;
      if (power_reg[`PCR_PWR_HD2] && (sync2_reg[0] != sync3_reg[0])) wake = 1'b1;
      if (power_reg[`PCR_PWR_HD1] && (sync2_reg[1] != sync3_reg[1])) wake = 1'b1;
      if (power_reg[`PCR_PWR_OTG] && (sync2_reg[2] != sync3_reg[2])) wake = 1'b1;
      if (power_reg[`PCR_PWR_SERIAL] && (sync2_reg[3] != sync3_reg[3])) wake = 1'b1;
      if (power_reg[`PCR_PWR_SPI] && !sync2_reg[4] && sync3_reg[4]) wake = 1'b1;
      if (power_reg[`PCR_PWR_HOSTPORT] && sync2_reg[5] && !sync3_reg[5]) wake = 1'b1;
      if (power_reg[`PCR_PWR_GPI] && (sync2_reg[7:6] != sync3_reg[7:6])) wake = 1'b1;
   end

   // ==========================================================================
   // Power register and mode state; sleep outranks halt if both written
   always_ff @(posedge clk) begin
      if (reset) begin
         power_reg <= `PCR_RST_POWER;
         state_reg <= PCR_RUN;
      end else begin
         if (wr && hit(addr, `PCR_OFF_POWER)) begin
            power_reg <= wdata & `PCR_PWR_WR_MASK & ~16'h0003;
         end
         unique case (state_reg)
            PCR_RUN: begin
               if (wr && hit(addr, `PCR_OFF_POWER) && wdata[`PCR_PWR_SLEEP]) begin
                  state_reg <= PCR_SLEEP;
               end else if (wr && hit(addr, `PCR_OFF_POWER) && wdata[`PCR_PWR_HALT]) begin
                  state_reg <= PCR_HALT;
               end
            end
            PCR_HALT: begin
               if ((irq_pending & irq_en_reg) != 16'h0000) begin
                  state_reg <= PCR_RUN;
               end
            end
            PCR_SLEEP: begin
               if (wake) begin
                  state_reg <= PCR_RUN;
               end
            end
         endcase
      end
   end

   // ==========================================================================
   // Processor clock divider; peripherals keep the full clock
   always_ff @(posedge clk) begin
      if (reset) begin
         div_cnt_reg <= 4'h0;
      end else if (state_reg == PCR_RUN) begin
         div_cnt_reg <= (div_cnt_reg >= speed_reg) ? 4'h0 : div_cnt_reg + 4'h1;
      end
   end

   // Enables for the core and peripheral clock gates
   always_comb begin
      cpu_clk_en    = (state_reg == PCR_RUN) && (div_cnt_reg == 4'h0);
      periph_clk_en = (state_reg != PCR_SLEEP);
      sleep_active  = (state_reg == PCR_SLEEP);
      break_hit     = (break_reg != 16'h0000) && (cpu_pc == break_reg);
      usb_diag      = diag_reg;
   end

   // ==========================================================================
   // Sticky events; a set in the clear cycle survives
   always_comb begin
      evt_set = 3'b000;
      evt_set[`PCR_EVT_WAKE]     = (state_reg == PCR_SLEEP) && wake;
      evt_set[`PCR_EVT_HALT_END] = (state_reg == PCR_HALT) &&
                                   ((irq_pending & irq_en_reg) != 16'h0000);
      evt_set[`PCR_EVT_BREAK]    = break_hit;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         evt_stat_reg <= 3'b000;
      end else if (wr && hit(addr, `PCR_OFF_EVT_CLR)) begin
         evt_stat_reg <= (evt_stat_reg & ~wdata[2:0]) | evt_set;
      end else begin
         evt_stat_reg <= evt_stat_reg | evt_set;
      end
   end

   // Level interrupt while any enabled event is pending
   always_comb begin
      irq = |(evt_stat_reg & evt_en_reg);
   end

   // ==========================================================================
   // Read data, registered; unmapped and write-only addresses read zero
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= `PCR_RST_ZERO;
      end else if (rd) begin
         unique case (addr)
            `PCR_OFF_FLAGS:    rdata <= flags_reg & 16'h001F;
            `PCR_OFF_BANK:     rdata <= bank_reg;
            `PCR_OFF_REV:      rdata <= REVISION;
            `PCR_OFF_SPEED:    rdata <= {12'h000, speed_reg};
            `PCR_OFF_POWER:    rdata <= power_reg |
                                        {13'h0000, boost_not_ok, 2'b00};
            `PCR_OFF_IRQ_EN:   rdata <= irq_en_reg;
            `PCR_OFF_BREAK:    rdata <= break_reg;
            `PCR_OFF_EVT_STAT: rdata <= {13'h0000, evt_stat_reg};
            `PCR_OFF_EVT_EN:   rdata <= {13'h0000, evt_en_reg};
            default:           rdata <= `PCR_RST_ZERO;
         endcase
      end else begin
         rdata <= `PCR_RST_ZERO;
      end
   end

endmodule

// *** shared/pcr_map.svh ***
// Purpose : Offsets, field positions and reset values of the processor control block
// Assumes : 16-bit register words on a plain strobe port
// Notes   : Included by the design, the monitor and the bench
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// ==========================================================================
// Register offsets
`define PCR_OFF_FLAGS      16'hC000
`define PCR_OFF_BANK       16'hC002
`define PCR_OFF_REV        16'hC004
`define PCR_OFF_SPEED      16'hC008
`define PCR_OFF_POWER      16'hC00A
`define PCR_OFF_IRQ_EN     16'hC00E
`define PCR_OFF_BREAK      16'hC014
`define PCR_OFF_DIAG       16'hC03C
`define PCR_OFF_EVT_STAT   16'hC0F0
`define PCR_OFF_EVT_CLR    16'hC0F2
`define PCR_OFF_EVT_EN     16'hC0F4

// ==========================================================================
// Field positions and masks
`define PCR_FLAG_GIE       4
`define PCR_FLAG_NEG       3
`define PCR_FLAG_OVF       2
`define PCR_FLAG_CARRY     1
`define PCR_FLAG_ZERO      0
`define PCR_BANK_MASK      16'hFFF0
`define PCR_SPEED_MASK     16'h000F
`define PCR_PWR_WR_MASK    16'h5B93
`define PCR_PWR_HD2        14
`define PCR_PWR_HD1        12
`define PCR_PWR_OTG        11
`define PCR_PWR_SERIAL     9
`define PCR_PWR_SPI        8
`define PCR_PWR_HOSTPORT   7
`define PCR_PWR_GPI        4
`define PCR_PWR_BOOST      2
`define PCR_PWR_SLEEP      1
`define PCR_PWR_HALT       0
`define PCR_IRQEN_MASK     16'h1BEF
`define PCR_EVT_WAKE       0
`define PCR_EVT_HALT_END   1
`define PCR_EVT_BREAK      2

// ==========================================================================
// Reset values
`define PCR_RST_BANK       16'h0100
`define PCR_RST_SPEED      4'hF
`define PCR_RST_POWER      16'h0000
`define PCR_RST_IRQ_EN     16'h0010
`define PCR_RST_ZERO       16'h0000

`endif

// *** shared/pcr_pkg.sv ***
// Purpose : Types shared by the processor control block
// Assumes : Constants live in pcr_map.svh
// Notes   : Power state enum uses one-hot codes
package pcr_pkg;
   // ==========================================================================
   // Types
   typedef logic [15:0] pcr_word_t;             // One register word
   typedef enum logic [2:0] {
      PCR_RUN   = 3'b001,                       // Processor clocked
      PCR_HALT  = 3'b010,                       // Processor stopped only
      PCR_SLEEP = 3'b100                        // Whole chip paused
   } pcr_state_t;
endpackage
